//--- xds_cfg.svh
// register offsets, field positions, reset values and timing counts of the external data move sequencer
`ifndef XDS_CFG_SVH
`define XDS_CFG_SVH
`define XDS_A_CLOCK_CONTROL_REG     8'h00
`define XDS_A_PSEL      8'h04
`define XDS_A_DP0       8'h08
`define XDS_A_DP1       8'h0C
`define XDS_A_INDIR     8'h10
`define XDS_A_CMD       8'h14
`define XDS_A_STAT      8'h18
`define XDS_STRETCH_RST 3'h1
`define XDS_MC_LAST     5'h03
`define XDS_STB0_START  5'h01
`define XDS_STB0_WIDTH  5'h02
`define XDS_STB_START   5'h02
`define XDS_CNT_ZERO    5'h00
`define XDS_ONE_16      16'h0001
`define XDS_OP_LSB      0
`define XDS_OP_MSB      2
`define XDS_WD_LSB      8
`define XDS_WD_MSB      15
`define XDS_LD_LSB      16
`define XDS_LD_MSB      31
`define XDS_P2_LSB      8
`define XDS_P2_MSB      15
`endif

//--- xds_pkg.sv
// types shared by the external data move sequencer
package xds_pkg;
    typedef enum logic [2:0] {
        XDS_OP_NONE, XDS_OP_RD_DP, XDS_OP_WR_DP, XDS_OP_RD_RI, XDS_OP_WR_RI,
        XDS_OP_INC_DP, XDS_OP_LD_DP, XDS_OP_INC_SEL
    } xds_op_t;
    typedef enum logic [1:0] {XDS_ST_IDLE, XDS_ST_FETCH, XDS_ST_ACC} xds_st_t;
    // external data memory pins, strobes active low
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        data_oe;
        logic        rd_n;
        logic        wr_n;
    } xds_ext_t;
endpackage

//--- xds_ctrl.sv
// external data move sequencer with stretch control, dual data pointers and apb registers
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "xds_cfg.svh"

module xds_ctrl (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [7:0]      ext_rdata,
    output xds_pkg::xds_ext_t    ext_q
);

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // strobe width in clocks for a stretch code
    function automatic logic [4:0] stb_width(input logic [2:0] s);
        stb_width = (s == 3'h0) ? `XDS_STB0_WIDTH : {s, 2'b00};
    endfunction

    function automatic logic [4:0] stb_start(input logic [2:0] s);
        stb_start = (s == 3'h0) ? `XDS_STB0_START : `XDS_STB_START;
    endfunction

    // strobe window inside the access cycles
    function automatic logic stb_on(input logic [2:0] s, input logic [4:0] c);
        stb_on = (c >= stb_start(s)) && (c < stb_start(s) + stb_width(s));
    endfunction

    function automatic logic is_move(input xds_pkg::xds_op_t op);
        is_move = (op == xds_pkg::XDS_OP_RD_DP) || (op == xds_pkg::XDS_OP_WR_DP) ||
                  (op == xds_pkg::XDS_OP_RD_RI) || (op == xds_pkg::XDS_OP_WR_RI);
    endfunction

    function automatic logic is_read(input xds_pkg::xds_op_t op);
        is_read = (op == xds_pkg::XDS_OP_RD_DP) || (op == xds_pkg::XDS_OP_RD_RI);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [2:0]        stretch_q;
    logic              sel_q;
    logic [15:0]       dp0_q;
    logic [15:0]       dp1_q;
    logic [7:0]        ri_q;
    logic [7:0]        p2_q;
    logic [7:0]        rdata_q;
    logic [7:0]        wbyte_q;
    logic [15:0]       ldval_q;
    logic [2:0]        str_q;
    xds_pkg::xds_op_t  op_q;
    xds_pkg::xds_st_t  st_q;
    xds_pkg::xds_st_t  st_d;
    logic [4:0]        cnt_q;
    logic [4:0]        cnt_d;
    logic              access;
    logic              wr_go;
    logic              busy;
    logic              start;
    logic              fetch_end;
    logic              mapped;
    logic              dp_move;

    assign access    = psel && penable && pready;
    assign wr_go     = access && pwrite && !pslverr;
    assign busy      = (st_q != xds_pkg::XDS_ST_IDLE);
    assign start     = wr_go && (paddr == `XDS_A_CMD);
    assign fetch_end = (st_q == xds_pkg::XDS_ST_FETCH) && (cnt_q == `XDS_MC_LAST);
    assign dp_move   = (op_q == xds_pkg::XDS_OP_RD_DP) || (op_q == xds_pkg::XDS_OP_WR_DP);
    assign mapped    = (paddr == `XDS_A_CLOCK_CONTROL_REG) || (paddr == `XDS_A_PSEL) || (paddr == `XDS_A_DP0) ||
                       (paddr == `XDS_A_DP1) || (paddr == `XDS_A_INDIR) || (paddr == `XDS_A_CMD) ||
                       (paddr == `XDS_A_STAT);

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer registered

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            // unmapped, and a command while a move runs, are refused
            pslverr <= !mapped || (pwrite && busy && (paddr == `XDS_A_CMD));
            case (paddr)
                `XDS_A_CLOCK_CONTROL_REG: prdata <= {29'h0, stretch_q};
                `XDS_A_PSEL:  prdata <= {31'h0, sel_q};
                `XDS_A_DP0:   prdata <= {16'h0, dp0_q};
                `XDS_A_DP1:   prdata <= {16'h0, dp1_q};
                `XDS_A_INDIR: prdata <= {16'h0, p2_q, ri_q};
                `XDS_A_CMD:   prdata <= {24'h0, rdata_q};
                `XDS_A_STAT:  prdata <= {26'h0, st_q == xds_pkg::XDS_ST_ACC, st_q, busy, str_q[1:0]};
                default:      prdata <= 32'h0000_0000;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    // stretch field, three bits of the clock control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch_q <= `XDS_STRETCH_RST;
        end else if (wr_go && paddr == `XDS_A_CLOCK_CONTROL_REG) begin
            stretch_q <= pwdata[2:0];
        end
    end

    // pointer select: apb write beats an increment in the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 1'b0;
        end else if (wr_go && paddr == `XDS_A_PSEL) begin
            sel_q <= pwdata[0];
        end else if (fetch_end && op_q == xds_pkg::XDS_OP_INC_SEL) begin
            sel_q <= !sel_q;
        end
    end

    // data pointers: loads and increments go to the selected one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp0_q <= 16'h0000;
            dp1_q <= 16'h0000;
        end else begin
            if (wr_go && paddr == `XDS_A_DP0) begin
                dp0_q <= pwdata[15:0];
            end else if (fetch_end && !sel_q && op_q == xds_pkg::XDS_OP_INC_DP) begin
                dp0_q <= dp0_q + `XDS_ONE_16;
            end else if (fetch_end && !sel_q && op_q == xds_pkg::XDS_OP_LD_DP) begin
                dp0_q <= ldval_q;
            end
            if (wr_go && paddr == `XDS_A_DP1) begin
                dp1_q <= pwdata[15:0];
            end else if (fetch_end && sel_q && op_q == xds_pkg::XDS_OP_INC_DP) begin
                dp1_q <= dp1_q + `XDS_ONE_16;
            end else if (fetch_end && sel_q && op_q == xds_pkg::XDS_OP_LD_DP) begin
                dp1_q <= ldval_q;
            end
        end
    end

    // working register low byte and port 2 high byte for indirect moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ri_q <= 8'h00;
            p2_q <= 8'hFF;
        end else if (wr_go && paddr == `XDS_A_INDIR) begin
            ri_q <= pwdata[7:0];
            p2_q <= pwdata[`XDS_P2_MSB:`XDS_P2_LSB];
        end
    end

    // command capture; stretch locked so a mid-move write cannot tear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q    <= xds_pkg::XDS_OP_NONE;
            wbyte_q <= 8'h00;
            ldval_q <= 16'h0000;
            str_q   <= `XDS_STRETCH_RST;
        end else if (start) begin
            op_q    <= xds_pkg::xds_op_t'(pwdata[`XDS_OP_MSB:`XDS_OP_LSB]);
            wbyte_q <= pwdata[`XDS_WD_MSB:`XDS_WD_LSB];
            ldval_q <= pwdata[`XDS_LD_MSB:`XDS_LD_LSB];
            str_q   <= stretch_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + 5'h01;
        case (st_q)
            xds_pkg::XDS_ST_IDLE: begin
                cnt_d = `XDS_CNT_ZERO;
                if (start) begin
                    st_d = xds_pkg::XDS_ST_FETCH;
                end
            end
            xds_pkg::XDS_ST_FETCH: begin
                if (cnt_q == `XDS_MC_LAST) begin
                    cnt_d = `XDS_CNT_ZERO;
                    // non-moves end after the fetch, stretch unused
                    st_d = is_move(op_q) ? xds_pkg::XDS_ST_ACC : xds_pkg::XDS_ST_IDLE;
                end
            end
            xds_pkg::XDS_ST_ACC: begin
                if (cnt_q == {str_q, 2'b11}) begin
                    cnt_d = `XDS_CNT_ZERO;
                    st_d  = xds_pkg::XDS_ST_IDLE;
                end
            end
            default: begin
                cnt_d = `XDS_CNT_ZERO;
                st_d  = xds_pkg::XDS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= xds_pkg::XDS_ST_IDLE;
            cnt_q <= `XDS_CNT_ZERO;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external pins, registered so strobes are glitch free

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q <= '{addr: 16'h0000, wdata: 8'h00, data_oe: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
        end else begin
            if (fetch_end && is_move(op_q)) begin
                ext_q.addr  <= dp_move ? (sel_q ? dp1_q : dp0_q) : {p2_q, ri_q};
                ext_q.wdata <= wbyte_q;
            end
            // data bus driven across the whole write access
            ext_q.data_oe <= (st_d == xds_pkg::XDS_ST_ACC) && !is_read(op_q);
            ext_q.rd_n    <= !((st_d == xds_pkg::XDS_ST_ACC) && is_read(op_q) && stb_on(str_q, cnt_d));
            ext_q.wr_n    <= !((st_d == xds_pkg::XDS_ST_ACC) && !is_read(op_q) && stb_on(str_q, cnt_d));
        end
    end

    // read data taken in the last strobe clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 8'h00;
        end else if (!ext_q.rd_n && !stb_on(str_q, cnt_q + 5'h01)) begin
            rdata_q <= ext_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [5:0] acc_clks_q;
    logic [4:0] stb_clks_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_clks_q <= 6'h00;
            stb_clks_q <= 5'h00;
        end else begin
            acc_clks_q <= (st_q == xds_pkg::XDS_ST_ACC) ? acc_clks_q + 6'h01 : 6'h00;
            stb_clks_q <= (!ext_q.rd_n || !ext_q.wr_n) ? stb_clks_q + 5'h01 : 5'h00;
        end
    end

    fetch_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_q == xds_pkg::XDS_ST_ACC) |-> $past(st_q == xds_pkg::XDS_ST_FETCH, 4)
            && $past(st_q == xds_pkg::XDS_ST_IDLE, 5))
        else $error("access did not follow a four clock fetch");

    access_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_q == xds_pkg::XDS_ST_ACC) && !dp_move |-> ext_q.addr == $past({p2_q, ri_q}))
        else $error("indirect address wrong at access start");

    move_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(st_q == xds_pkg::XDS_ST_ACC) |-> acc_clks_q == {1'b0, str_q, 2'b00} + 6'h04)
        else $error("access length not stretch plus one machine cycles");

    short_op_a: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_end && !is_move(op_q) |=> st_q == xds_pkg::XDS_ST_IDLE)
        else $error("non-move op was stretched");

    strobe_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ext_q.rd_n && ext_q.wr_n) |-> stb_clks_q == stb_width(str_q))
        else $error("strobe width wrong for stretch code");

    pointer_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_q == xds_pkg::XDS_ST_ACC) && dp_move |->
            ext_q.addr == ($past(sel_q) ? $past(dp1_q) : $past(dp0_q)))
        else $error("wrong data pointer used");

    addr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == xds_pkg::XDS_ST_ACC && $past(st_q == xds_pkg::XDS_ST_ACC) |->
            $stable(ext_q.addr) && $stable(ext_q.wdata))
        else $error("address or data moved during access");

    strobe_inside_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(ext_q.rd_n && ext_q.wr_n) |-> st_q == xds_pkg::XDS_ST_ACC && !(!ext_q.rd_n && !ext_q.wr_n))
        else $error("strobe outside access cycles");

    stretch_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> stretch_q == `XDS_STRETCH_RST)
        else $error("stretch field not one after reset");

    read_zero_c: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(ext_q.rd_n) && str_q == 3'h0);
    write_max_c: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(ext_q.wr_n) && str_q == 3'h7);
    sel_toggle_c: cover property (@(posedge pclk) disable iff (!presetn)
        fetch_end && op_q == xds_pkg::XDS_OP_INC_SEL);

endmodule

//--- xds_mem.sv
// external data memory model on the far side of the move sequencer
`timescale 1ns/1ps
module xds_mem (
    input  wire logic              pclk,
    input  wire xds_pkg::xds_ext_t ext_q,
    output logic [7:0]             rdata
);
    logic [7:0] mem_q [256];
    logic [7:0] last_q = 8'hA5;

    ////////////////////////////////////////////////////////////////////////////////
    // answer only while the read strobe is low; an inverted stale byte otherwise,
    // so a sequencer sampling outside its strobe sees wrong data, not a lucky match
    assign rdata = ext_q.rd_n ? ~last_q : mem_q[ext_q.addr[7:0]];

    // take write data at every clock of a low write strobe
    always_ff @(posedge pclk) begin
        if (!ext_q.wr_n) begin
            mem_q[ext_q.addr[7:0]] <= ext_q.wdata;
        end
        last_q <= rdata;
    end
endmodule

//--- xds_ctrl_tb.sv
// self-checking bench of the external data move sequencer
`timescale 1ns/1ps
`include "xds_cfg.svh"
module xds_ctrl_tb;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [7:0]        ext_rdata;
    xds_pkg::xds_ext_t ext_q;
    logic [31:0]       rd_q;
    logic              err_q;
    int                error_cnt;
    int                n_tests;

    xds_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_rdata(ext_rdata), .ext_q(ext_q));
    xds_mem mem (.pclk(pclk), .ext_q(ext_q), .rdata(ext_rdata));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(exp, rd_q);
    endtask

    // issue one command, then watch the pins clock by clock for a fixed 4 * s + 12 clocks
    task automatic move(input logic [2:0] op, input logic [7:0] wb, input logic [15:0] ea, input int s);
        int          k;
        int          f;
        int          sw;
        int          oe;
        logic [15:0] a;
        logic [7:0]  d;
        f = 0;
        sw = 0;
        oe = 0;
        apb(1'b1, `XDS_A_CMD, {ea, wb, 5'h00, op});
        chk(32'h0, {31'h0, err_q});
        for (k = 1; k <= 4 * s + 12; k++) begin
            @(posedge pclk);
            #1;
            oe += ext_q.data_oe;
            if (!ext_q.rd_n || !ext_q.wr_n) begin
                if (sw == 0) begin
                    f = k;
                    a = ext_q.addr;
                    d = ext_q.wdata;
                end
                sw++;
                chk({a, d}, {ext_q.addr, ext_q.wdata});
            end
        end
        if (op >= 3'h1 && op <= 3'h4) begin
            chk(ea, a);
            chk((s == 0) ? 2 : 4 * s, sw);
            chk(4 + ((s == 0) ? 1 : 2), f);
        end else begin
            chk(0, sw + oe);
        end
        if (op == 3'h2 || op == 3'h4) begin
            chk(4 * (s + 1), oe);
            chk(wb, d);
        end else begin
            chk(0, oe);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and an unmapped address
    task automatic t_reset();
        rd(`XDS_A_CLOCK_CONTROL_REG, 32'h1);
        rd(`XDS_A_PSEL, 32'h0);
        rd(`XDS_A_INDIR, 32'h0000FF00);
        rd(`XDS_A_DP0, 32'h0);
        rd(`XDS_A_DP1, 32'h0);
        rd(`XDS_A_STAT, 32'h1);
        rd(8'h1C, 32'h0);
        chk(32'h1, {31'h0, err_q});
        apb(1'b1, 8'h1C, 32'hFFFFFFFF);
        chk(32'h1, {31'h0, err_q});
    endtask

    // every stretch code: write then read back through the primary pointer
    task automatic t_stretch();
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, `XDS_A_CLOCK_CONTROL_REG, 32'hFFFFFFF8 | s);
            rd(`XDS_A_CLOCK_CONTROL_REG, s);
            apb(1'b1, `XDS_A_DP0, 32'h1200 + s);
            move(3'h2, 8'hC0 + s, 16'h1200 + s, s);
            move(3'h1, 8'h00, 16'h1200 + s, s);
            rd(`XDS_A_CMD, 8'hC0 + s);
        end
    endtask

    // pointer selection, increment, toggle and load
    task automatic t_pointer();
        apb(1'b1, `XDS_A_CLOCK_CONTROL_REG, 32'h1);
        apb(1'b1, `XDS_A_DP0, 32'h2211);
        apb(1'b1, `XDS_A_DP1, 32'h4433);
        apb(1'b1, `XDS_A_PSEL, 32'hFF);
        rd(`XDS_A_PSEL, 32'h1);
        move(3'h5, 8'h00, 16'h0000, 1);
        rd(`XDS_A_DP1, 32'h4434);
        rd(`XDS_A_DP0, 32'h2211);
        move(3'h2, 8'h77, 16'h4434, 1);
        move(3'h7, 8'h00, 16'h0000, 1);
        rd(`XDS_A_PSEL, 32'h0);
        move(3'h6, 8'h00, 16'h4434, 1);
        rd(`XDS_A_DP0, 32'h4434);
        move(3'h1, 8'h00, 16'h4434, 1);
        rd(`XDS_A_CMD, 32'h77);
    endtask

    // register-indirect moves take port2 as the high byte
    task automatic t_indirect();
        apb(1'b1, `XDS_A_INDIR, 32'h5A3C);
        move(3'h4, 8'h99, 16'h5A3C, 1);
        move(3'h3, 8'h00, 16'h5A3C, 1);
        rd(`XDS_A_CMD, 32'h99);
    endtask

    // a pointer op is not stretched, a move is; a command during a move is refused
    task automatic t_timing();
        apb(1'b1, `XDS_A_CLOCK_CONTROL_REG, 32'h7);
        apb(1'b1, `XDS_A_CMD, 32'h5);
        repeat (2) @(posedge pclk);
        apb(1'b1, `XDS_A_CMD, 32'h5);
        chk(32'h0, {31'h0, err_q});
        repeat (6) @(posedge pclk);
        apb(1'b1, `XDS_A_CMD, 32'h1);
        apb(1'b1, `XDS_A_CMD, 32'h5);
        chk(32'h1, {31'h0, err_q});
        // long access under way: busy, access state, locked stretch low bits
        rd(`XDS_A_STAT, 32'h37);
        repeat (50) @(posedge pclk);
        // both short increments landed, the refused one did not
        rd(`XDS_A_DP0, 32'h4436);
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        n_tests = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_stretch();
        t_pointer();
        t_indirect();
        t_timing();
        summarize();
    end
endmodule
